// [common/lintmc_pkg.sv]
// shared constants and types for the transceiver mode controller
package lintmc_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int WAKE_QUAL_US = 20;
	localparam int WAKE_QUAL_CYC = (WAKE_QUAL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MISMATCH_DLY_US = 25;
	localparam int MISMATCH_DLY_CYC = (MISMATCH_DLY_US * 1000) / CLK_PERIOD_NS;
	localparam int STUCK_DOM_US = 10000;
	localparam int STUCK_DOM_CYC = (STUCK_DOM_US * 1000) / CLK_PERIOD_NS;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic RST_PIN_LEVEL = 1'b0;

	// ----------------------------------------
	// modes
	// ----------------------------------------
	typedef enum logic [2:0] {
		LINTMC_POR = 3'h0,
		LINTMC_READY = 3'h1,
		LINTMC_OPERATION = 3'h2,
		LINTMC_DRIVER_OFF = 3'h3,
		LINTMC_POWER_DOWN = 3'h4
	} lintmc_mode_e;

	// ----------------------------------------
	// bundled status
	// ----------------------------------------
	typedef struct packed {
		logic transmitterOn;
		logic receiverOn;
		logic regulatorOn;
		logic pullupOn;
		logic activityDetectOn;
	} lintmc_power_s;

endpackage

// [hw/lintmc_mode_ctrl.sv]
// mode sequencer and driver gating for a single-wire bus transceiver
//
// Behaviour
// RULE1: driver off while enable pin low or stuck dominant detected.
// RULE2: driver may re-enable once the enable pin returns high.
// RULE3: host pulling enable high does not enable driver during internal fault.
// RULE4: stuck-dominant driver-off recovers when the stuck condition clears.
// RULE5: driver off while regulator unstable or recovering from a fault.
// RULE6: bus activity needs line below threshold for at least 20 us.
// RULE7: level variant leaves power-down on dominant longer than 20 us.
// RULE8: edge variant wakes only on fresh falling edge plus 20 us dominant.
// RULE9: select/wake high in power-down wakes to ready, then onward.
// RULE10: edge variant pull-up only in operation; level variant always.
// RULE11: level variant leaves ready only to operation; edge may go driver-off.
// RULE12: host lowers enable before raising select/wake to reach driver-off.
// RULE13: power-on reset keeps all off; ready once battery above 5.75 V.
// RULE14: edge variant ready: enable low to driver-off, high to operation.
// RULE15: select/wake low in operation or driver-off enters power-down.
// RULE16: driver-off with enable high returns to operation.
// RULE17: power-down keeps only activity detect; qualified bus fall goes ready.
// RULE18: ready held until regulator stable and select/wake high.
// RULE19: mismatch fault reported only 25 us after transmit falling edge.
// RULE20: stuck-dominant detection time is a module parameter.
`timescale 1ns/10ps
module lintmc_mode_ctrl
	import lintmc_pkg::*;
#(
	parameter bit EDGE_VARIANT = 1'b0,
	parameter int STUCK_CYC = STUCK_DOM_CYC,
	parameter int WAKE_CYC = WAKE_QUAL_CYC,
	parameter int MISMATCH_CYC = MISMATCH_DLY_CYC
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic batteryAboveOn,
	input wire logic batteryBelowOff,
	input wire logic regulatorStable,
	input wire logic regulatorFault,
	input wire logic thermalShutdown,
	input wire logic transmitData,
	input wire logic bus_line_low,
	input wire logic select_wake_pin,
	input wire logic fault_or_driver_enable_pin_in,
	output logic fault_or_driver_enable_pin_out,
	output logic fault_or_driver_enable_pin_oe,
	output logic bus_line_out,
	output logic bus_line_oe,
	output logic receiveData,
	output logic resetOut_n,
	output lintmc_power_s powerState,
	output lintmc_mode_e mode,
	output logic wakeFromBus
);

	// ----------------------------------------
	// pin synchronisation
	// ----------------------------------------
	logic [4:0] pinsSync;
	logic txdS;
	logic busLowS;
	logic selWakeS;
	logic enablePinS;
	logic batOnS;

	lintmc_sync #(.WIDTH(5)) u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.asyncIn({transmitData, bus_line_low, select_wake_pin,
			fault_or_driver_enable_pin_in, batteryAboveOn}),
		.syncOut(pinsSync)
	);

	assign {txdS, busLowS, selWakeS, enablePinS, batOnS} = pinsSync;

	// ----------------------------------------
	// bus activity qualification
	// ----------------------------------------
	logic busLowPrev_reg;
	logic busLowPrev_next;
	logic armed_reg;
	logic armed_next;
	logic busLowQual;

	// dominant for the qualification time
	lintmc_qual #(.COUNT(WAKE_CYC)) u_wake_qual (
		.core_clk(core_clk),
		.rst(rst),
		.cond(busLowS),
		.reached(busLowQual)
	); // [RULE6]

	// edge variant: armed only by a recessive-to-dominant transition
	always_comb
	begin
		busLowPrev_next = busLowS;
		armed_next = armed_reg;
		if (!busLowS)
			armed_next = 1'b0;
		else if (!busLowPrev_reg)
			armed_next = 1'b1; // [RULE8]
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			busLowPrev_reg <= 1'b1;
			armed_reg <= 1'b0;
		end
		else
		begin
			busLowPrev_reg <= busLowPrev_next;
			armed_reg <= armed_next;
		end
	end

	logic busWake;
	assign busWake = EDGE_VARIANT ? (busLowQual && armed_reg) : busLowQual; // [RULE7] [RULE8]

	// ----------------------------------------
	// stuck dominant and mismatch faults
	// ----------------------------------------
	logic stuckTxd;
	logic stuckBus;
	logic stuckDominant;

	lintmc_qual #(.COUNT(STUCK_CYC)) u_stuck_txd (
		.core_clk(core_clk),
		.rst(rst),
		.cond(!txdS),
		.reached(stuckTxd)
	); // [RULE20]

	lintmc_qual #(.COUNT(STUCK_CYC)) u_stuck_bus (
		.core_clk(core_clk),
		.rst(rst),
		.cond(busLowS),
		.reached(stuckBus)
	); // [RULE20]

	// clears as soon as the dominant level goes away
	assign stuckDominant = stuckTxd || stuckBus; // [RULE4]

	// mismatch: transmit low but line stays high, judged after the delay
	logic mismatchQual;
	lintmc_qual #(.COUNT(MISMATCH_CYC)) u_mismatch (
		.core_clk(core_clk),
		.rst(rst),
		.cond(!txdS && !busLowS),
		.reached(mismatchQual)
	); // [RULE19]

	// ----------------------------------------
	// mode state machine
	// ----------------------------------------
	lintmc_mode_e mode_reg;
	lintmc_mode_e mode_next;
	logic wakeFlag_reg;
	logic wakeFlag_next;
	logic internalFault;
	logic regulatorOk;

	assign regulatorOk = regulatorStable && !regulatorFault;
	assign internalFault = thermalShutdown || mismatchQual || !regulatorOk;

	always_comb
	begin
		mode_next = mode_reg;
		wakeFlag_next = wakeFlag_reg;
		if (batteryBelowOff)
			mode_next = LINTMC_POR;
		else
		begin
			unique case (mode_reg)
				LINTMC_POR:
				begin
					if (batOnS)
						mode_next = LINTMC_READY; // [RULE13]
				end
				LINTMC_READY:
				begin
					if (regulatorOk && selWakeS) // [RULE18]
					begin
						wakeFlag_next = 1'b0;
						if (EDGE_VARIANT && !enablePinS)
							mode_next = LINTMC_DRIVER_OFF; // [RULE11] [RULE14]
						else
							mode_next = LINTMC_OPERATION; // [RULE11] [RULE14]
					end
				end
				LINTMC_OPERATION:
				begin
					if (!selWakeS)
						mode_next = LINTMC_POWER_DOWN; // [RULE15]
					else if (!enablePinS || stuckDominant || internalFault)
						mode_next = LINTMC_DRIVER_OFF; // [RULE1] [RULE5]
				end
				LINTMC_DRIVER_OFF:
				begin
					if (!selWakeS)
						mode_next = LINTMC_POWER_DOWN; // [RULE15]
					else if (enablePinS && !internalFault && !stuckDominant)
						mode_next = LINTMC_OPERATION; // [RULE2] [RULE3] [RULE4] [RULE16]
				end
				LINTMC_POWER_DOWN:
				begin
					if (selWakeS)
						mode_next = LINTMC_READY; // [RULE9]
					else if (busWake)
					begin
						mode_next = LINTMC_READY; // [RULE17]
						wakeFlag_next = 1'b1;
					end
				end
				default:
					mode_next = LINTMC_POR;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			mode_reg <= LINTMC_POR;
			wakeFlag_reg <= 1'b0;
		end
		else
		begin
			mode_reg <= mode_next;
			wakeFlag_reg <= wakeFlag_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	logic driverAllowed;
	lintmc_power_s power_next;
	lintmc_power_s power_reg;
	logic faultDrive_reg;
	logic faultDrive_next;
	logic busDrive_reg;
	logic busDrive_next;
	logic rxd_reg;
	logic rxd_next;
	logic resetN_reg;
	logic resetN_next;

	assign driverAllowed = (mode_reg == LINTMC_OPERATION) && enablePinS && !stuckDominant
		&& !internalFault; // [RULE1] [RULE3] [RULE5]

	always_comb
	begin
		power_next.transmitterOn = driverAllowed;
		power_next.receiverOn = (mode_reg == LINTMC_READY) || (mode_reg == LINTMC_OPERATION)
			|| (mode_reg == LINTMC_DRIVER_OFF); // [RULE13] [RULE16]
		power_next.regulatorOn = power_next.receiverOn; // [RULE15]
		power_next.activityDetectOn = (mode_reg == LINTMC_POWER_DOWN); // [RULE17]
		power_next.pullupOn = EDGE_VARIANT ? (mode_reg == LINTMC_OPERATION) : 1'b1; // [RULE10]
		// open drain: pull low on internal fault or stuck dominant while active
		faultDrive_next = power_next.receiverOn && (internalFault || stuckDominant);
		busDrive_next = driverAllowed && !txdS;
		rxd_next = !busLowS;
		resetN_next = power_next.regulatorOn && regulatorOk;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			power_reg <= '0;
			faultDrive_reg <= RST_PIN_LEVEL;
			busDrive_reg <= RST_PIN_LEVEL;
			rxd_reg <= 1'b1;
			resetN_reg <= RST_PIN_LEVEL;
		end
		else
		begin
			power_reg <= power_next;
			faultDrive_reg <= faultDrive_next;
			busDrive_reg <= busDrive_next;
			rxd_reg <= rxd_next;
			resetN_reg <= resetN_next;
		end
	end

	assign powerState = power_reg;
	assign mode = mode_reg;
	assign wakeFromBus = wakeFlag_reg;
	assign receiveData = rxd_reg;
	assign resetOut_n = resetN_reg;
	assign fault_or_driver_enable_pin_out = 1'b0;
	assign fault_or_driver_enable_pin_oe = faultDrive_reg;
	assign bus_line_out = 1'b0;
	assign bus_line_oe = busDrive_reg;

endmodule

// [hw/lintmc_qual.sv]
// counts how long a condition has held; flags once the count is reached
`timescale 1ns/10ps
module lintmc_qual
	import lintmc_pkg::*;
#(
	parameter int COUNT = 2000
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cond,
	output logic reached
);

	localparam int CW = $clog2(COUNT + 1);
	localparam logic [CW-1:0] LIMIT = CW'(COUNT);

	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;

	always_comb
	begin
		cnt_next = cnt_reg;
		if (!cond)
			cnt_next = '0;
		else if (cnt_reg != LIMIT)
			cnt_next = cnt_reg + CW'(1);
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_next;
	end

	assign reached = cond && (cnt_reg == LIMIT);

endmodule

// [hw/lintmc_sync.sv]
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
module lintmc_sync
	import lintmc_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			stage1_reg <= '0;
			stage2_reg <= '0;
		end
		else
		begin
			stage1_reg <= asyncIn;
			stage2_reg <= stage1_reg;
		end
	end

	assign syncOut = stage2_reg;

endmodule

// [testbench/lintmc_host.sv]
// host controller model on the select, transmit and enable pins
`timescale 1ns/10ps
module lintmc_host
(
	input wire logic core_clk,
	input wire logic wantSel,
	input wire logic wantTx,
	input wire logic holdTxeLow,
	input wire logic devPullLow,
	output logic select_wake_pin = 1'b0,
	output logic transmitData = 1'b1,
	output logic enablePin
);
	always @(negedge core_clk)
	begin
		transmitData <= wantTx;
		// select follows wantSel; enablePin is already low whenever holdTxeLow is set
		select_wake_pin <= wantSel && !(holdTxeLow && enablePin);
	end
	// open drain with pull-up: low when either side pulls
	assign enablePin = !(devPullLow || holdTxeLow);
endmodule

// [testbench/lintmc_mode_ctrl_asserts.sv]
// concurrent checks on the mode controller ports
`timescale 1ns/10ps
module lintmc_mode_ctrl_asserts
	import lintmc_pkg::*;
#(
	parameter int WAKE_CYC = WAKE_QUAL_CYC
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic regulatorStable,
	input wire logic bus_line_low,
	input wire logic select_wake_pin,
	input wire logic bus_line_oe,
	input wire lintmc_power_s powerState,
	input wire lintmc_mode_e mode,
	input wire logic wakeFromBus
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	a_drv_op_only: assert property (bus_line_oe |-> $past(mode) == LINTMC_OPERATION)
		else $error("driver on outside operation");
	a_por_all_off: assert property ($past(mode) == LINTMC_POR |-> !powerState.transmitterOn
		&& !powerState.receiverOn && !powerState.regulatorOn)
		else $error("supply on in power-on reset");
	a_pdown_power: assert property ($past(mode) == LINTMC_POWER_DOWN |->
		powerState.activityDetectOn && !powerState.regulatorOn && !powerState.transmitterOn)
		else $error("wrong supplies in power-down");
	a_pullup_level: assert property ($past(mode) != LINTMC_POR |-> powerState.pullupOn)
		else $error("pull-up dropped");
	a_ready_hold: assert property (mode == LINTMC_READY && !regulatorStable |=>
		mode != LINTMC_OPERATION)
		else $error("left ready with regulator unstable");
	a_sel_wake: assert property (mode == LINTMC_POWER_DOWN && select_wake_pin |->
		##[1:4] mode == LINTMC_READY)
		else $error("select did not wake");
	a_sel_sleep: assert property ((!select_wake_pin) [*4] |->
		!(mode inside {LINTMC_OPERATION, LINTMC_DRIVER_OFF}))
		else $error("select low did not power down");
	a_bus_qual: assert property ($rose(wakeFromBus) |->
		$past(bus_line_low, WAKE_CYC) && $past(bus_line_low, 3))
		else $error("bus wake without qualified dominant");
	cover property (mode == LINTMC_DRIVER_OFF);
	cover property ($rose(wakeFromBus));
	cover property (mode == LINTMC_POWER_DOWN ##1 mode == LINTMC_READY);
endmodule

// [testbench/lintmc_mode_ctrl_test.sv]
// self-checking bench for the transceiver mode controller
`timescale 1ns/10ps
module lintmc_mode_ctrl_test
	import lintmc_pkg::*;
;
	logic core_clk, rst, regulatorStable, extLow, wantSel, wantTx, holdTxeLow;
	logic thermal, regFault;
	wire logic select_wake_pin, transmitData, enablePin, txeOe, bus_line_oe, wakeFromBus;
	wire logic rxData, resetOut_n;
	lintmc_power_s powerState;
	lintmc_mode_e mode;
	logic [31:0] lfsrState;
	int errors, samples_checked;
	// bus is dominant when our driver or another node pulls it
	wire logic bus_line_low = bus_line_oe || extLow;

	lintmc_mode_ctrl #(.STUCK_CYC(50), .WAKE_CYC(10), .MISMATCH_CYC(12)) lintmc_mode_ctrl_i (
		.core_clk(core_clk), .rst(rst), .batteryAboveOn(1'b1), .batteryBelowOff(1'b0),
		.regulatorStable(regulatorStable), .regulatorFault(regFault), .thermalShutdown(thermal),
		.transmitData(transmitData), .bus_line_low(bus_line_low),
		.select_wake_pin(select_wake_pin), .fault_or_driver_enable_pin_in(enablePin),
		.fault_or_driver_enable_pin_out(), .fault_or_driver_enable_pin_oe(txeOe),
		.bus_line_out(), .bus_line_oe(bus_line_oe), .receiveData(rxData),
		.resetOut_n(resetOut_n),
		.powerState(powerState), .mode(mode), .wakeFromBus(wakeFromBus));
	lintmc_host lintmc_host_i (.core_clk(core_clk), .wantSel(wantSel), .wantTx(wantTx),
		.holdTxeLow(holdTxeLow), .devPullLow(txeOe), .select_wake_pin(select_wake_pin),
		.transmitData(transmitData), .enablePin(enablePin));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic run(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task final_report;
		if (errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial
	begin
		#100000;
		errors++;
		final_report;
	end
	initial
	begin
		{rst, regulatorStable, extLow, wantSel, wantTx, holdTxeLow} = 6'b10_0010;
		{thermal, regFault} = 2'b00;
		lfsrState = 32'h0b5e_9d81;
		errors = 0;
		samples_checked = 0;
		run(12);
		rst = 1'b0;
		run(6);
		chk(mode, LINTMC_READY);
		wantSel = 1'b1;
		run(10);
		chk(mode, LINTMC_READY);
		regulatorStable = 1'b1;
		run(6);
		chk(mode, LINTMC_OPERATION);
		repeat (20)
		begin
			lfsrState = lfsr(lfsrState);
			wantTx = lfsrState[0] | lfsrState[1];
			run(5);
			chk(bus_line_oe, !wantTx);
		end
		wantTx = 1'b1;
		holdTxeLow = 1'b1;
		run(6);
		chk({mode, bus_line_oe}, {LINTMC_DRIVER_OFF, 1'b0});
		holdTxeLow = 1'b0;
		run(6);
		chk(mode, LINTMC_OPERATION);
		wantTx = 1'b0;
		run(80);
		chk(bus_line_oe, 1'b0);
		wantTx = 1'b1;
		run(12);
		chk(mode, LINTMC_OPERATION);
		wantTx = 1'b0;
		run(5);
		regulatorStable = 1'b0;
		run(4);
		chk(bus_line_oe, 1'b0);
		{wantTx, regulatorStable} = 2'b11;
		run(12);
		chk(mode, LINTMC_OPERATION);
		thermal = 1'b1;
		run(6);
		chk({mode, bus_line_oe}, {LINTMC_DRIVER_OFF, 1'b0});
		chk(txeOe, 1'b1);
		thermal = 1'b0;
		run(8);
		chk(mode, LINTMC_OPERATION);
		wantTx = 1'b0;
		run(5);
		chk(bus_line_oe, 1'b1);
		regFault = 1'b1;
		run(4);
		chk(bus_line_oe, 1'b0);
		{wantTx, regFault} = 2'b10;
		run(12);
		chk(mode, LINTMC_OPERATION);
		wantSel = 1'b0;
		run(5);
		chk(mode, LINTMC_POWER_DOWN);
		chk(resetOut_n, 1'b0);
		extLow = 1'b1;
		run(8);
		chk(mode, LINTMC_POWER_DOWN);
		extLow = 1'b0;
		run(3);
		extLow = 1'b1;
		run(20);
		chk({mode, wakeFromBus}, {LINTMC_READY, 1'b1});
		chk(rxData, 1'b0);
		extLow = 1'b0;
		wantSel = 1'b1;
		run(6);
		wantSel = 1'b0;
		run(5);
		wantSel = 1'b1;
		run(8);
		chk(mode, LINTMC_OPERATION);
		final_report;
	end
endmodule

bind lintmc_mode_ctrl lintmc_mode_ctrl_asserts #(.WAKE_CYC(WAKE_CYC)) lintmc_mode_ctrl_asserts_i (
	.core_clk(core_clk), .rst(rst), .regulatorStable(regulatorStable),
	.bus_line_low(bus_line_low), .select_wake_pin(select_wake_pin),
	.bus_line_oe(bus_line_oe), .powerState(powerState), .mode(mode),
	.wakeFromBus(wakeFromBus));
